// *** inc/ext_irq_params.svh ***
// Purpose: Named offsets, field positions and reset values for the
//          external interrupt source selection block.
// Assumes: 32-bit Avalon-MM register bus, word-aligned byte addresses.
// Notes:   Definitions only.
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_SOURCE_SELECT 4'h0
`define OFS_EDGE_RISE 4'h4
`define OFS_EDGE_FALL 4'h8
`define OFS_IRQ_STATUS 4'hc

// ----------------------------------------------------------------
// Reset values and field codes
// ----------------------------------------------------------------
`define RST_SOURCE_SELECT 16'h0000
`define RST_EDGE 8'h00
`define RST_IRQ_MASK 8'h00
`define SEL_PIN 2'h0
`define SEL_ALT 2'h1
`define SEL_OR 2'h2
`define SEL_AND 2'h3
`define MASK_LANE 1
`define OFS_IRQ_MASK 4'h0
`define NUM_CHANNELS 8
`define ZERO8 8'h00
`define ZERO32 32'h0000_0000
`define UNMAPPED_READ 32'h0000_0000

`endif

// *** inc/ext_irq_pkg.sv ***
// Purpose: Types shared by the external interrupt source selection block.
// Assumes: Nothing beyond the parameter header.
// Notes:   Bus carriers are packed structs.
`default_nettype none
package ext_irq_pkg;
  // Avalon-MM request from the master
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_type;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic waitrequest;
    logic readdatavalid;
    logic [31:0] readdata;
  } avmm_rsp_type;

  // Bus handshake phases
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DONE = 2'b01
  } bus_state_type;
endpackage
`default_nettype wire

// *** hdl/ext_irq_source_select.sv ***
// Purpose: Fast external interrupt front end with source selection,
//          edge detection, sticky flags and one masked interrupt line.
// Assumes: Pins and on-chip sources are asynchronous to clock; 125 MHz.
// Notes:   Each request sees one wait cycle; waitrequest is then low for
//          one cycle, and a write lands at the edge where it is seen low.
//
// Overview of operation
// - Channel edges: rising, falling, or both
// - Channel input may come from peripheral
// - Code 00 pin only, 01 alternate only
// - Code 10 ORs pin and alternate
// - Code 11 ANDs pin and alternate
// - Eight 2-bit fields, channel x bits 2x+1:2x
// - Ch2 pin10/RTC timed, ch3 pin11/RTC alarm
// - Ch4-7 pins12-15, alternate constant zero
`include "ext_irq_params.svh"
`default_nettype none

module ext_irq_source_select (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register bus
  input wire ext_irq_pkg::avmm_req_type avmm_req,
  output ext_irq_pkg::avmm_rsp_type avmm_rsp,
  // Interrupt inputs
  input wire logic [7:0] port_pins,
  input wire logic first_can_receive_line,
  input wire logic second_can_receive_line,
  input wire logic rtc_timed_event,
  input wire logic rtc_alarm_event,
  // Interrupt output
  output logic irq
);
  import ext_irq_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Combine pin and alternate source per select code
  function automatic logic combine(input logic [1:0] sel, input logic pin,
                                   input logic alt);
    logic r;
    r = pin;
    case (sel)
      `SEL_PIN: r = pin;
      `SEL_ALT: r = alt;
      `SEL_OR: r = pin | alt;
      `SEL_AND: r = pin & alt;
      default: r = pin;
    endcase
    return r;
  endfunction

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Source combining and synchronisers
  // ----------------------------------------------------------------
  logic [7:0] alt_src;
  logic [7:0] raw_in;
  logic [7:0] sync1_ff, sync2_ff, prev_ff;
  logic [7:0] nxt_sync1, nxt_sync2, nxt_prev;
  logic [7:0] alt_sync1_ff, alt_sync2_ff;
  logic [7:0] nxt_alt_sync1, nxt_alt_sync2;
  logic [15:0] source_select_ff, nxt_source_select;
  logic [7:0] rise_en_ff, nxt_rise_en;
  logic [7:0] fall_en_ff, nxt_fall_en;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] edge_evt;

  // Alternate source mapping per channel
  assign alt_src = {4'h0, rtc_alarm_event, rtc_timed_event,
                    second_can_receive_line, first_can_receive_line};

  // Channel x takes field bits 2x+1:2x; only settled copies are combined
  always_comb begin
    for (int c = 0; c < `NUM_CHANNELS; c++) begin
      raw_in[c] = combine(source_select_ff[2*c +: 2], sync2_ff[c],
                          alt_sync2_ff[c]);
    end
  end

  // Two-stage synchronisers per line, then edge history of the choice.
  // Each line is brought in on its own before any gate sees it, so a
  // glitch of the OR or AND between two unrelated lines is never caught
  // as a short pulse. A change of the select code acts at once on the
  // settled copies and may itself make an edge; software clears it.
  always_comb begin
    nxt_sync1 = port_pins;
    nxt_sync2 = sync1_ff;
    nxt_alt_sync1 = alt_src;
    nxt_alt_sync2 = alt_sync1_ff;
    nxt_prev = raw_in;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= `ZERO8;
      sync2_ff <= `ZERO8;
      alt_sync1_ff <= `ZERO8;
      alt_sync2_ff <= `ZERO8;
      prev_ff <= `ZERO8;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      alt_sync1_ff <= nxt_alt_sync1;
      alt_sync2_ff <= nxt_alt_sync2;
      prev_ff <= nxt_prev;
    end
  end

  // Qualified edges per channel
  // Both enables set give an event on either edge
  assign edge_evt = (raw_in & ~prev_ff & rise_en_ff) |
                    (~raw_in & prev_ff & fall_en_ff);

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  bus_state_type bus_ff, nxt_bus;
  avmm_rsp_type rsp_ff, nxt_rsp;
  logic req_act;
  logic rd_status;

  assign req_act = avmm_req.read | avmm_req.write;
  assign rd_status = (bus_ff == BUS_IDLE) && avmm_req.read &&
                     (avmm_req.address == `OFS_IRQ_STATUS);

  // Handshake, register writes and read data.
  // A request is seen in idle and answered with read data at once; the
  // write itself waits for the done cycle, where the master samples
  // waitrequest low, so a written register never changes before the master knows.
  always_comb begin
    logic [31:0] rd;
    rd = `UNMAPPED_READ;
    nxt_bus = BUS_IDLE;
    nxt_rsp = rsp_ff;
    nxt_rsp.waitrequest = 1'b1;
    nxt_rsp.readdatavalid = 1'b0;
    nxt_source_select = source_select_ff;
    nxt_rise_en = rise_en_ff;
    nxt_fall_en = fall_en_ff;
    nxt_mask = mask_ff;
    case (bus_ff)
      BUS_IDLE: begin
        if (req_act) begin
          nxt_bus = BUS_DONE;
          nxt_rsp.waitrequest = 1'b0;
          case (avmm_req.address)
            `OFS_SOURCE_SELECT: rd = {16'h0000, source_select_ff};
            `OFS_EDGE_RISE: rd = {24'h000000, rise_en_ff};
            `OFS_EDGE_FALL: rd = {24'h000000, fall_en_ff};
            `OFS_IRQ_STATUS: rd = {16'h0000, mask_ff, status_ff};
            default: rd = `UNMAPPED_READ;
          endcase
          if (avmm_req.read) begin
            nxt_rsp.readdata = rd;
            nxt_rsp.readdatavalid = 1'b1;
          end
        end
      end
      BUS_DONE: begin
        nxt_bus = BUS_IDLE;
        nxt_rsp.waitrequest = 1'b1;
        // Master samples waitrequest low at this edge: writes land here
        if (avmm_req.write) begin
          case (avmm_req.address)
            `OFS_SOURCE_SELECT: nxt_source_select = 16'(merge(
              {16'h0000, source_select_ff}, avmm_req.writedata,
              avmm_req.byteenable));
            `OFS_EDGE_RISE: nxt_rise_en = 8'(merge({24'h000000,
              rise_en_ff}, avmm_req.writedata, avmm_req.byteenable));
            `OFS_EDGE_FALL: nxt_fall_en = 8'(merge({24'h000000,
              fall_en_ff}, avmm_req.writedata, avmm_req.byteenable));
            `OFS_IRQ_STATUS: begin
              if (avmm_req.byteenable[`MASK_LANE]) begin
                nxt_mask = avmm_req.writedata[8*`MASK_LANE +: 8];
              end
            end
            default: nxt_mask = mask_ff;
          endcase
        end
      end
      default: nxt_bus = BUS_IDLE;
    endcase
  end

  // Sticky status: read clears, a same-cycle edge wins
  // The clear falls on the accept edge, after the read snapshot is taken
  always_comb begin
    nxt_status = status_ff;
    if (rd_status) begin
      nxt_status = `ZERO8;
    end
    nxt_status = nxt_status | edge_evt;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_ff <= BUS_IDLE;
      rsp_ff <= '{waitrequest: 1'b1, readdatavalid: 1'b0,
                  readdata: `ZERO32};
      source_select_ff <= `RST_SOURCE_SELECT;
      rise_en_ff <= `RST_EDGE;
      fall_en_ff <= `RST_EDGE;
      mask_ff <= `RST_IRQ_MASK;
      status_ff <= `ZERO8;
      irq <= 1'b0;
    end else begin
      bus_ff <= nxt_bus;
      rsp_ff <= nxt_rsp;
      source_select_ff <= nxt_source_select;
      rise_en_ff <= nxt_rise_en;
      fall_en_ff <= nxt_fall_en;
      mask_ff <= nxt_mask;
      status_ff <= nxt_status;
      irq <= |(nxt_status & nxt_mask);
    end
  end

  assign avmm_rsp = rsp_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Input path checks
  a_rise_sets_flag: assert property (
    (raw_in[0] && !prev_ff[0] && rise_en_ff[0]) |=> status_ff[0])
    else $error("rising edge did not set flag");
  a_fall_sets_flag: assert property (
    (!raw_in[1] && prev_ff[1] && fall_en_ff[1]) |=> status_ff[1])
    else $error("falling edge did not set flag");
  a_pin_mode_path: assert property (
    (source_select_ff[1:0] == `SEL_PIN && $stable(source_select_ff))
      |-> raw_in[0] == sync2_ff[0])
    else $error("pin mode wrong");
  a_alt_mode_path: assert property (
    (source_select_ff[3:2] == `SEL_ALT) |-> raw_in[1] ==
      alt_sync2_ff[1])
    else $error("alternate mode wrong");
  a_or_mode_path: assert property (
    (source_select_ff[5:4] == `SEL_OR) |-> raw_in[2] ==
      (sync2_ff[2] | alt_sync2_ff[2]))
    else $error("or mode wrong");
  a_and_mode_path: assert property (
    (source_select_ff[7:6] == `SEL_AND) |-> raw_in[3] ==
      (sync2_ff[3] & alt_sync2_ff[3]))
    else $error("and mode wrong");
  a_unused_alt_zero: assert property (
    (source_select_ff[9:8] == `SEL_ALT) |-> !raw_in[4])
    else $error("unused alternate not zero");
  a_unused_and_zero: assert property (
    (source_select_ff[15:14] == `SEL_AND) |-> !raw_in[7])
    else $error("unused alternate leaked in and mode");
  a_sync_two_stage: assert property (
    port_pins[0] |=> ##1 sync2_ff[0] == $past(port_pins[0], 2))
    else $error("synchroniser depth wrong");
  a_alt_line_depth: assert property (
    second_can_receive_line |=> ##1
      alt_sync2_ff[1] == $past(second_can_receive_line, 2))
    else $error("alternate synchroniser depth wrong");

  // Bus and flag checks
  a_write_field: assert property (
    (bus_ff == BUS_DONE && avmm_req.write && avmm_req.byteenable[0] &&
     avmm_req.address == `OFS_SOURCE_SELECT)
      |=> source_select_ff[7:0] == $past(avmm_req.writedata[7:0]))
    else $error("select write lost");
  a_wait_one_cycle: assert property (
    !avmm_rsp.waitrequest |=> avmm_rsp.waitrequest)
    else $error("waitrequest low too long");
  a_done_to_idle: assert property (
    (bus_ff == BUS_DONE) |=> (bus_ff == BUS_IDLE))
    else $error("bus stuck after answer");
  a_read_clears: assert property (
    (rd_status && !edge_evt[0]) |=> !status_ff[0])
    else $error("status read did not clear flag");
  a_irq_level: assert property (
    irq == |(status_ff & mask_ff))
    else $error("irq level wrong");

  c_rise_event: cover property (edge_evt[0] ##1 irq);
  c_status_read: cover property (rd_status && |status_ff);
  c_alt_mode: cover property (source_select_ff[1:0] == `SEL_ALT);
  c_and_mode: cover property (source_select_ff[15:14] == `SEL_AND);
  c_both_edges: cover property (
    rise_en_ff[0] && fall_en_ff[0] && edge_evt[0]);
endmodule
`default_nettype wire

// *** sim/irq_source_model.sv ***
// Purpose: Far-side model of the port pins and on-chip alternate sources.
// Assumes: Lines change right after a rising clock edge.
// Notes:   Levels hold until the next call, as real pins do.
`default_nettype none
module irq_source_model (
  // Clock
  input wire logic clock,
  // Lines into the block
  output logic [7:0] port_pins,
  output logic first_can_receive_line,
  output logic second_can_receive_line,
  output logic rtc_timed_event,
  output logic rtc_alarm_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines at time zero
  initial begin
    port_pins = 8'h00;
    {rtc_alarm_event, rtc_timed_event} = 2'h0;
    {second_can_receive_line, first_can_receive_line} = 2'h0;
  end
  // New levels after an edge; alternate bit i feeds channel i
  task automatic set_lines(input logic [7:0] p, input logic [3:0] a);
    @(posedge clock);
    port_pins <= p;
    {rtc_alarm_event, rtc_timed_event} <= a[3:2];
    {second_can_receive_line, first_can_receive_line} <= a[1:0];
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the interrupt source selection block.
// Assumes: One request at a time; about three edges from pin to flag.
// Notes:   Status reads clear flags, so each check reads once.
`include "ext_irq_params.svh"
`default_nettype none
`define CHECK(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_irq_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  avmm_req_type req = '0;
  avmm_rsp_type rsp;
  wire logic [7:0] pins;
  wire logic [3:0] alt;
  wire logic irq;
  logic [31:0] d;
  logic dv;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Clock and hang guard
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  irq_source_model model (.clock(clock), .port_pins(pins),
    .first_can_receive_line(alt[0]), .second_can_receive_line(alt[1]),
    .rtc_timed_event(alt[2]), .rtc_alarm_event(alt[3]));
  ext_irq_source_select uut (.clock(clock), .reset_n(reset_n),
    .avmm_req(req), .avmm_rsp(rsp), .port_pins(pins),
    .first_can_receive_line(alt[0]), .second_can_receive_line(alt[1]),
    .rtc_timed_event(alt[2]), .rtc_alarm_event(alt[3]), .irq(irq));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic [3:0] ad, input logic wr,
                     input logic [31:0] wd, input logic [3:0] be);
    @(posedge clock);
    req.address <= ad;
    req.read <= !wr;
    req.write <= wr;
    req.writedata <= wd;
    req.byteenable <= be;
    do @(posedge clock); while (rsp.waitrequest !== 1'b0);
    d = rsp.readdata;
    dv = rsp.readdatavalid;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  // Reads and compares; status reads keep only the flag byte
  task automatic chk(input logic [3:0] ad, input logic [31:0] ex,
                     input string nm);
    bus(ad, 1'b0, 32'h0, 4'hf);
    `CHECK("read valid", 1'b1, dv)
    `CHECK(nm, ex, d & ((ad == `OFS_IRQ_STATUS) ? 32'hff : 32'hffffffff))
  endtask
  // Sets lines and lets the synchroniser and flag settle
  task automatic drive(input logic [7:0] p, input logic [3:0] a);
    model.set_lines(p, a);
    repeat (6) @(posedge clock);
  endtask
  // Expected combined input of one channel
  function automatic logic comb(input logic [1:0] c, input logic p,
                                input logic a);
    return (c == 2'h0) ? p : (c == 2'h1) ? a : (c == 2'h2) ? p | a : p & a;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] c;
    logic p;
    logic a;
    logic [31:0] ex;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    chk(`OFS_SOURCE_SELECT, 32'h0000, "select reset");
    chk(`OFS_EDGE_RISE, 32'h00, "rise reset");
    chk(4'h2, `UNMAPPED_READ, "unmapped");
    bus(`OFS_SOURCE_SELECT, 1'b1, 32'h0000_e4a5, 4'hf);
    chk(`OFS_SOURCE_SELECT, 32'h0000_e4a5, "select rw");
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    chk(`OFS_SOURCE_SELECT, 32'h0000, "select after reset");
    $display("test registers done");
    bus(`OFS_IRQ_STATUS, 1'b1, 32'h0000_ff00, 4'h2);
    bus(`OFS_EDGE_RISE, 1'b1, 32'hff, 4'hf);
    for (int k = 0; k < 16; k++) begin
      c = k[3:2];
      p = k[1];
      a = k[0];
      bus(`OFS_SOURCE_SELECT, 1'b1, {16'h0, {8{c}}}, 4'hf);
      drive(8'h00, 4'h0);
      bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, 4'hf);
      drive({8{p}}, {4{a}});
      ex = {24'h0, {4{comb(c, p, 1'b0)}}, {4{comb(c, p, a)}}};
      chk(`OFS_IRQ_STATUS, ex, "mode flags");
    end
    $display("test modes done");
    for (int i = 0; i < 8; i++) begin
      bus(`OFS_SOURCE_SELECT, 1'b1, 32'h0, 4'hf);
      drive(8'h00, 4'h0);
      bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, 4'hf);
      drive(8'h01 << i, 4'h0);
      chk(`OFS_IRQ_STATUS, 32'h1 << i, "pin wiring");
      if (i < 4) begin
        bus(`OFS_SOURCE_SELECT, 1'b1, 32'h5555, 4'hf);
        drive(8'h00, 4'h0);
        bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, 4'hf);
        drive(8'h00, 4'h1 << i);
        chk(`OFS_IRQ_STATUS, 32'h1 << i, "alt wiring");
      end
    end
    $display("test wiring done");
    bus(`OFS_SOURCE_SELECT, 1'b1, 32'h0, 4'hf);
    for (int m = 1; m < 4; m++) begin
      bus(`OFS_EDGE_RISE, 1'b1, {24'h0, {8{m[0]}}}, 4'hf);
      bus(`OFS_EDGE_FALL, 1'b1, {24'h0, {8{m[1]}}}, 4'hf);
      drive(8'h00, 4'h0);
      bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, 4'hf);
      drive(8'hff, 4'h0);
      chk(`OFS_IRQ_STATUS, {24'h0, {8{m[0]}}}, "rise flags");
      drive(8'h00, 4'h0);
      chk(`OFS_IRQ_STATUS, {24'h0, {8{m[1]}}}, "fall flags");
    end
    $display("test edges done");
    bus(`OFS_IRQ_STATUS, 1'b1, 32'h0, 4'h2);
    drive(8'h0f, 4'h0);
    `CHECK("irq masked", 1'b0, irq)
    bus(`OFS_IRQ_STATUS, 1'b1, 32'h0000_0800, 4'h2);
    repeat (3) @(posedge clock);
    `CHECK("irq raised", 1'b1, irq)
    chk(`OFS_IRQ_STATUS, 32'h0f, "irq status");
    repeat (3) @(posedge clock);
    `CHECK("irq cleared", 1'b0, irq)
    $display("test interrupt done");
    test_done();
  end
endmodule
`default_nettype wire
